// ---- core/bus_service_request_and_holdoff.sv ----
`timescale 1ns/100ps
// What this block does
// - Mask weights 1,2,4,8,16,32 pick which conditions may raise SRQ.
// - Summed weights enable several conditions; every matching bit set.
// - A mask write of zero clears all bits, no SRQ possible.
// - Power-up and device clear clear the mask.
// - Status bit 0 follows overrange input.
// - Status bit 1 set when readings reach buffer size.
// - Status bit 2 set when readings reach half buffer size.
// - Status bit 3 set when the conversion completes.
// - Status bit 4 set when all commands processed and ready.
// - Status bit 5 set on any of the error conditions.
// - Status bit 6 set when this device asserted SRQ.
// - Status bit 7 always reads zero.
// - Whole status byte frozen while a request is pending.
// - Serial poll releases SRQ and clears bit 6.
// - Illegal option sets error; SRQ with bit 6 if errors enabled.
// - Mode 0 EOI+hold, 1 hold only, 2 EOI only, 3 neither.
// - Power-up and device clear restore default mode.
// - Hold-off after execute byte handshake; NRFD held until processed.
// - Modes 0 and 1 also hold off on EOI or terminator.
// - Hold-off 160 ms function, 660 ms AC, 117 ms others, cal whole.
// - Error word read clears error bits and re-arms error SRQ.
module bus_service_request_and_holdoff #(
    parameter longint FUNC_CYC = srq_pkg::FUNC_CYC,
    parameter longint AC_FUNC_CYC = srq_pkg::AC_FUNC_CYC,
    parameter longint OTHER_CYC = srq_pkg::OTHER_CYC,
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Device clear (DCL or selected SDC), one-cycle pulse
    input wire logic dev_clear_i,
    // Mask and mode writes from the command parser
    input wire logic mask_wr_i,
    input wire logic [7:0] mask_data_i,
    input wire logic mode_wr_i,
    input wire logic [1:0] mode_data_i,
    // Live instrument conditions
    input wire srq_pkg::cond_t cond_i,
    input wire logic invalid_command_error_i,
    input wire logic invalid_option_error_i,
    input wire logic other_error_i,
    // Error word query read by the controller
    input wire logic error_word_query_i,
    // Serial poll of the status byte
    input wire logic spoll_i,
    // Command-string events
    input wire logic exec_done_i,
    input wire logic eoi_rx_i,
    input wire logic term_rx_i,
    input wire srq_pkg::cmd_kind_t cmd_kind_i,
    input wire logic cal_done_i,
    // Bus outputs
    output logic srq_o,
    output logic [7:0] status_byte_o,
    output logic eoi_enable_o,
    output logic nrfd_hold_o,
    output logic [1:0] mode_o,
    output logic [7:0] mask_o
);

    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic error_reg;
    logic error_next;
    logic err_srq_arm_reg;
    logic err_srq_arm_next;
    logic srq_reg;
    logic srq_next;
    logic [7:0] latch_reg;
    logic [7:0] latch_next;

    wire logic clear_all;
    wire logic err_event;
    wire logic [5:0] live_cond;
    wire logic [5:0] armed_mask;
    wire logic [5:0] hit;
    wire logic raise;
    wire logic [7:0] live_byte;
    wire logic hold_on;
    wire logic hold_trig;
    wire logic [CNT_W-1:0] hold_count;
    wire logic hold_busy;

    assign clear_all = rst_i | dev_clear_i;

    // Any error source sets the sticky error flag
    assign err_event = invalid_command_error_i | invalid_option_error_i
        | other_error_i;

    // Set wins over the read-clear of the error word
    assign error_next = err_event ? 1'b1
        : (error_word_query_i ? 1'b0 : error_reg);

    // Error SRQ fires once, then ignores later errors until an error word read re-arms it.
    // Disarm only on a real raise, so a poll cycle cannot swallow it
    assign err_srq_arm_next = error_word_query_i ? 1'b1
        : ((raise && hit[srq_pkg::BIT_ERROR]) ? 1'b0
        : err_srq_arm_reg);

    // Live condition vector in mask-bit order
    assign live_cond = {error_next, cond_i.ready, cond_i.done,
        cond_i.half, cond_i.full, cond_i.overflow};

    // Error bit only requests while armed
    assign armed_mask = {mask_reg[srq_pkg::BIT_ERROR] & err_srq_arm_reg,
        mask_reg[srq_pkg::BIT_READY:srq_pkg::BIT_OVERFLOW]};

    assign hit = live_cond & armed_mask;
    assign raise = (srq_reg == 1'b0) && (hit != 6'h00) && !spoll_i;

    // Bit 7 tied low, bit 6 set with the request
    assign live_byte = {1'b0, 1'b1, live_cond};

    // Mask write stores the summed weights bit for bit
    assign mask_next = clear_all ? srq_pkg::MASK_RESET
        : (mask_wr_i ? (mask_data_i & {2'b00, srq_pkg::COND_MASK_BITS})
        : mask_reg);

    assign mode_next = clear_all ? srq_pkg::MODE_RESET
        : (mode_wr_i ? mode_data_i : mode_reg);

    // Poll releases the line; raise only when not polled this cycle
    assign srq_next = clear_all ? 1'b0
        : (spoll_i ? 1'b0 : (raise ? 1'b1 : srq_reg));

    // Freeze the byte at request time so the poll sees its cause
    assign latch_next = clear_all ? srq_pkg::STATUS_RESET
        : (raise ? live_byte
        : (spoll_i ? {1'b0, 1'b0, latch_reg[5:0]} : latch_reg));

    // Register updates
    always_ff @(posedge mclk_i) begin
        mask_reg <= mask_next;
        mode_reg <= mode_next;
        srq_reg <= srq_next;
        latch_reg <= latch_next;
        if (clear_all) begin
            error_reg <= 1'b0;
            err_srq_arm_reg <= 1'b1;
        end else begin
            error_reg <= error_next;
            err_srq_arm_reg <= err_srq_arm_next;
        end
    end

    // Status byte: frozen copy while a request stands, else live
    assign status_byte_o = srq_reg ? latch_reg
        : {1'b0, 1'b0, error_reg, cond_i.ready, cond_i.done,
        cond_i.half, cond_i.full, cond_i.overflow};

    assign srq_o = srq_reg;
    assign mask_o = mask_reg;
    assign mode_o = mode_reg;

    // EOI in modes 0 and 2; hold-off in modes 0 and 1
    assign eoi_enable_o = (mode_reg == srq_pkg::MODE_EOI_HOLD)
        || (mode_reg == srq_pkg::MODE_EOI);
    assign hold_on = (mode_reg == srq_pkg::MODE_EOI_HOLD)
        || (mode_reg == srq_pkg::MODE_HOLD);

    // Hold-off starts after the execute byte handshake ends, or on EOI or terminator
    assign hold_trig = hold_on && !clear_all
        && (exec_done_i || eoi_rx_i || term_rx_i);

    // Length chosen from command kind; cal waits for the core
    assign hold_count = (cmd_kind_i == srq_pkg::CMD_AC_FUNC)
        ? CNT_W'(AC_FUNC_CYC)
        : ((cmd_kind_i == srq_pkg::CMD_FUNC) ? CNT_W'(FUNC_CYC)
        : CNT_W'(OTHER_CYC));

    holdoff_timer #(
        .CNT_W(CNT_W)
    ) u_timer (
        .mclk_i(mclk_i),
        .rst_i(clear_all),
        .start_i(hold_trig),
        .count_i(hold_count),
        .wait_ext_i(cmd_kind_i == srq_pkg::CMD_CAL),
        .ext_done_i(cal_done_i),
        .busy_o(hold_busy)
    );

    assign nrfd_hold_o = hold_busy;

endmodule : bus_service_request_and_holdoff

// ---- core/srq_pkg.sv ----
package srq_pkg;

    // Mask and status bit positions
    localparam int BIT_OVERFLOW = 0;
    localparam int BIT_FULL = 1;
    localparam int BIT_HALF = 2;
    localparam int BIT_DONE = 3;
    localparam int BIT_READY = 4;
    localparam int BIT_ERROR = 5;
    localparam int BIT_RQS = 6;
    localparam int COND_W = 6;

    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [5:0] COND_MASK_BITS = 6'h3f;

    // End/hold-off modes
    localparam logic [1:0] MODE_EOI_HOLD = 2'h0;
    localparam logic [1:0] MODE_HOLD = 2'h1;
    localparam logic [1:0] MODE_EOI = 2'h2;
    localparam logic [1:0] MODE_NONE = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h0;

    // Hold-off times, in ms, and cycles at 100 MHz
    localparam longint CLK_HZ = 100_000_000;
    localparam longint FUNC_MS = 160;
    localparam longint AC_FUNC_MS = 660;
    localparam longint OTHER_MS = 117;
    localparam longint FUNC_CYC = FUNC_MS * CLK_HZ / 1000;
    localparam longint AC_FUNC_CYC = AC_FUNC_MS * CLK_HZ / 1000;
    localparam longint OTHER_CYC = OTHER_MS * CLK_HZ / 1000;

    // Kind of command that sets the hold-off length
    typedef enum logic [1:0] {
        CMD_OTHER,
        CMD_FUNC,
        CMD_AC_FUNC,
        CMD_CAL
    } cmd_kind_t;

    // Live conditions from the instrument core
    typedef struct packed {
        logic error;
        logic ready;
        logic done;
        logic half;
        logic full;
        logic overflow;
    } cond_t;

endpackage : srq_pkg

// ---- core/holdoff_timer.sv ----
`timescale 1ns/100ps
// Counts a hold-off period; cal holds until the core says done
module holdoff_timer #(
    parameter int CNT_W = 32
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Control
    input wire logic start_i,
    input wire logic [CNT_W-1:0] count_i,
    input wire logic wait_ext_i,
    input wire logic ext_done_i,
    // Status
    output logic busy_o
);

    logic [CNT_W-1:0] cnt_reg;
    logic ext_reg;
    logic busy_reg;

    // Count down; external wait ends only on core's done
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            ext_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else if (start_i) begin
            cnt_reg <= count_i;
            ext_reg <= wait_ext_i;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            if (ext_reg) begin
                busy_reg <= !ext_done_i;
            end else if (cnt_reg <= 1) begin
                busy_reg <= 1'b0;
            end else begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

    assign busy_o = busy_reg;

endmodule : holdoff_timer

// ---- tb/srq_asserts.sv ----
`timescale 1ns/100ps
// Watches request, status byte and hold-off outputs
module srq_asserts (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Inputs watched
    input wire logic dev_clear_i,
    input wire logic mask_wr_i,
    input wire logic [7:0] mask_data_i,
    input wire logic spoll_i,
    input wire logic exec_done_i,
    // Outputs watched
    input wire logic srq_o,
    input wire logic [7:0] status_byte_o,
    input wire logic eoi_enable_o,
    input wire logic nrfd_hold_o,
    input wire logic [1:0] mode_o,
    input wire logic [7:0] mask_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Request raised, then answered by a poll
    sequence raised;
        $rose(srq_o);
    endsequence
    sequence polled;
        srq_o ##0 spoll_i;
    endsequence
    mask_load_a: assert property (
        mask_wr_i && !dev_clear_i |=> mask_o == {2'h0, $past(mask_data_i[5:0])})
        else $error("mask not loaded");
    clear_all_a: assert property (
        dev_clear_i |=> mask_o == 8'h00 && mode_o == 2'h0 && !srq_o)
        else $error("clear missed");
    bit7_zero_a: assert property (status_byte_o[7] == 1'h0)
        else $error("bit 7 set");
    rqs_shown_a: assert property (srq_o |-> status_byte_o[6])
        else $error("bit 6 low while requesting");
    byte_frozen_a: assert property (
        srq_o && $past(srq_o) |-> $stable(status_byte_o))
        else $error("status moved while latched");
    poll_release_a: assert property (
        polled |=> !srq_o && !status_byte_o[6])
        else $error("poll did not release");
    raise_masked_a: assert property (
        raised |-> $past(mask_o) != 8'h00)
        else $error("request with empty mask");
    eoi_mode_a: assert property (eoi_enable_o == !mode_o[0])
        else $error("eoi enable wrong");
    hold_start_a: assert property (
        exec_done_i && !mode_o[1] && !dev_clear_i |=> nrfd_hold_o)
        else $error("hold-off missing");
    no_hold_a: assert property (
        $rose(nrfd_hold_o) |-> !$past(mode_o[1]))
        else $error("hold-off in mode 2 or 3");
endmodule : srq_asserts

bind bus_service_request_and_holdoff srq_asserts srq_asserts_inst (.*);

// ---- tb/ctrl_model.sv ----
`timescale 1ns/100ps
// Bus controller: polls once per request, promptly or late
module ctrl_model (
    // Clock
    input wire logic mclk_i,
    // Bus side
    input wire logic srq_i,
    input wire logic poll_en_i,
    input wire logic [3:0] delay_i,
    output logic spoll_o
);
    logic [3:0] wait_reg = 4'h0;
    // Falling edge, so the device samples a settled poll
    always @(negedge mclk_i) begin
        spoll_o <= 1'h0;
        if (poll_en_i && srq_i && !spoll_o) begin
            wait_reg <= (wait_reg == delay_i) ? 4'h0 : wait_reg + 4'h1;
            spoll_o <= (wait_reg == delay_i);
        end
    end
endmodule : ctrl_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
module tb;
    typedef struct packed {
        logic [7:0] mask;
        logic [5:0] cond;
        logic [7:0] st;
    } row_t;
    // Mask, live conditions, expected status byte
    row_t rows [8] = '{'{8'h01, 6'h01, 8'h41}, '{8'h02, 6'h02, 8'h42},
        '{8'h04, 6'h04, 8'h44}, '{8'h08, 6'h08, 8'h48},
        '{8'h10, 6'h10, 8'h50}, '{8'h05, 6'h04, 8'h44},
        '{8'h00, 6'h1f, 8'h1f}, '{8'h3b, 6'h04, 8'h04}};
    logic mclk_i = 1'h0, rst_i = 1'h1, clr = 1'h0, mwr = 1'h0, owr = 1'h0;
    logic ecmd = 1'h0, eopt = 1'h0, eoth = 1'h0, query = 1'h0;
    logic exec = 1'h0, eoi = 1'h0, term = 1'h0, poll_en = 1'h0, cald = 1'h0;
    logic srq, eoe, nrfd, spoll;
    logic [7:0] mdat = 8'h00, st, mask;
    logic [5:0] cond = 6'h00;
    logic [3:0] dly = 4'h0;
    logic [1:0] odat = 2'h0, mode;
    srq_pkg::cmd_kind_t kind = srq_pkg::CMD_OTHER;
    int mismatches = 0, checked = 0;
    // Short hold-off counts keep the run brief
    bus_service_request_and_holdoff #(.FUNC_CYC(20), .AC_FUNC_CYC(40),
        .OTHER_CYC(10)) bus_service_request_and_holdoff_inst (
        .mclk_i(mclk_i), .rst_i(rst_i), .dev_clear_i(clr),
        .mask_wr_i(mwr), .mask_data_i(mdat), .mode_wr_i(owr),
        .mode_data_i(odat), .cond_i(srq_pkg::cond_t'(cond)),
        .invalid_command_error_i(ecmd), .invalid_option_error_i(eopt),
        .other_error_i(eoth), .error_word_query_i(query), .spoll_i(spoll),
        .exec_done_i(exec), .eoi_rx_i(eoi), .term_rx_i(term),
        .cmd_kind_i(kind), .cal_done_i(cald), .srq_o(srq),
        .status_byte_o(st), .eoi_enable_o(eoe), .nrfd_hold_o(nrfd),
        .mode_o(mode), .mask_o(mask));
    ctrl_model ctrl_model_inst (.mclk_i(mclk_i), .srq_i(srq),
        .poll_en_i(poll_en), .delay_i(dly), .spoll_o(spoll));
    always #5 mclk_i = ~mclk_i;
    task automatic tally_and_finish;
        if (mismatches == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [7:0] seen, exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'h1;
        tick(1);
        s = 1'h0;
    endtask : pulse
    // Bounded wait for the request line
    task automatic wait_srq(input logic v);
        for (int i = 0; i < 40 && srq !== v; i++) tick(1);
        if (srq !== v) begin
            mismatches++;
            tally_and_finish();
        end
    endtask : wait_srq
    // Trigger on exec, EOI or terminator and measure NRFD
    task automatic hold(input logic [2:0] src, input logic [7:0] n);
        logic [7:0] cnt;
        cnt = 8'h00;
        {term, eoi, exec} = src;
        tick(1);
        {term, eoi, exec} = 3'h0;
        while (nrfd === 1'h1 && cnt < 8'h80) begin
            cnt++;
            tick(1);
        end
        chk(cnt, n, "hold");
    endtask : hold
    initial begin
        tick(5);
        rst_i = 1'h0;
        chk(mask, 8'h00, "mask");
        chk({5'h0, mode, eoe}, 8'h01, "mode");
        foreach (rows[i]) begin
            cond = 6'h00;
            pulse(clr);
            // Full mask first, so a zero write must clear set bits
            mdat = 8'h3f;
            pulse(mwr);
            mdat = rows[i].mask;
            pulse(mwr);
            cond = rows[i].cond;
            tick(2);
            chk({7'h0, srq}, {7'h0, rows[i].st[6]}, "srq");
            chk(st, rows[i].st, "status");
        end
        // Latched byte must ignore later changes
        cond = 6'h01;
        mdat = 8'h01;
        pulse(mwr);
        tick(1);
        cond = 6'h18;
        tick(2);
        chk(st, 8'h41, "frozen");
        cond = 6'h00;
        poll_en = 1'h1;
        wait_srq(1'h0);
        tick(1);
        chk(st, 8'h00, "polled");
        // Error request, slow poll, re-arm by error word read
        dly = 4'h6;
        mdat = 8'h20;
        pulse(mwr);
        pulse(eopt);
        tick(1);
        chk(st, 8'h60, "error");
        wait_srq(1'h0);
        pulse(ecmd);
        tick(2);
        chk(st, 8'h20, "once");
        pulse(query);
        tick(1);
        chk(st, 8'h00, "cleared");
        pulse(eoth);
        tick(1);
        chk(st, 8'h60, "rearmed");
        wait_srq(1'h0);
        // Every end/hold-off mode
        for (int m = 0; m < 4; m++) begin
            odat = m[1:0];
            pulse(owr);
            chk({6'h0, mode}, m[7:0], "mode");
            chk({7'h0, eoe}, {7'h0, ~m[0]}, "eoi");
            hold(3'h1, m[1] ? 8'h00 : 8'h0a);
        end
        hold(3'h2, 8'h00);
        odat = 2'h1;
        pulse(owr);
        kind = srq_pkg::CMD_FUNC;
        hold(3'h2, 8'h14);
        kind = srq_pkg::CMD_AC_FUNC;
        hold(3'h4, 8'h28);
        // Calibration holds until the core reports done
        kind = srq_pkg::CMD_CAL;
        exec = 1'h1;
        tick(1);
        exec = 1'h0;
        tick(60);
        chk({7'h0, nrfd}, 8'h01, "cal hold");
        pulse(cald);
        chk({7'h0, nrfd}, 8'h00, "cal end");
        pulse(clr);
        chk({6'h0, mode}, 8'h00, "cleared mode");
        chk(mask, 8'h00, "cleared mask");
        tally_and_finish();
    end
endmodule : tb
